/* design/vip_defs.vh */
// Constants of the vectored interrupt prioritizer: sizes, default channels, reset values.
// Assumes inclusion by bare name from each design file that needs it.
//
// Behaviour
// - Sixty-four request channels; every peripheral request lands on one of them.
// - Several sources on one channel share it; any of them activates it.
// - Each channel has its own enable mask blocking its requests from the core.
// - Each channel is configured as fast or normal interrupt type.
// - Lowest channel number wins; channel 0 is highest priority.
// - Error unit high interrupt on channel 0; channel 1 reserved, no source.
// - Tick timer compares 0 to 3 on channels 2 to 5 ascending.
// - Tick timer overflows on channels 6 and 7, timebase on 8.
// - High-end timer level 1 on channel 10, level 2 on 24.
// - Timer transfer unit level 1 on channel 11, level 2 on 25.
// - Buffered serial port one level 0 on channel 12, level 1 on 26.
// - Interconnect port one level 0 on channel 13, level 1 on 27.
// - Converter one: event 14, software 1 on 15, software 2 on 28, magnitude 31.
// - CAN controller one level 0 on 16, level 1 on 29; 17, 30 reserved.
// - Dual-channel automotive bus controller level 0 on channel 18.
// - Error unit low interrupt on channel 20.
// - System software interrupt on channel 21.
`ifndef VIP_DEFS_VH
`define VIP_DEFS_VH

`define VIP_NUM_CHAN        64
`define VIP_CHAN_W          6

`define VIP_CH_ERR_HIGH     6'h00
`define VIP_CH_RSVD_NMI     6'h01
`define VIP_CH_TICK_CMP0    6'h02
`define VIP_CH_TICK_OVF0    6'h06
`define VIP_CH_TICK_OVF1    6'h07
`define VIP_CH_TICK_TBASE   6'h08
`define VIP_CH_HET_L1       6'h0A
`define VIP_CH_HTU_L1       6'h0B
`define VIP_CH_SPI1_L0      6'h0C
`define VIP_CH_LIP1_L0      6'h0D
`define VIP_CH_ADC1_EVT     6'h0E
`define VIP_CH_ADC1_SW1     6'h0F
`define VIP_CH_CAN1_L0      6'h10
`define VIP_CH_RSVD_A       6'h11
`define VIP_CH_DBUS_L0      6'h12
`define VIP_CH_ERR_LOW      6'h14
`define VIP_CH_SW_INT       6'h15
`define VIP_CH_HET_L2       6'h18
`define VIP_CH_HTU_L2       6'h19
`define VIP_CH_SPI1_L1      6'h1A
`define VIP_CH_LIP1_L1      6'h1B
`define VIP_CH_ADC1_SW2     6'h1C
`define VIP_CH_CAN1_L1      6'h1D
`define VIP_CH_RSVD_B       6'h1E
`define VIP_CH_ADC1_MAG     6'h1F

`define VIP_RST_LINE        1'b0
`define VIP_RST_CHAN        6'h00
`define VIP_RST_PEND        64'h0000_0000_0000_0000

`endif

/* design/vip_prio_enc.v */
// Lowest-index-wins priority encoder over the 64 channel requests.
// Assumes a purely combinational caller; result is registered outside.
`include "vip_defs.vh"

module vip_prio_enc (
	// Requests
	input  wire [`VIP_NUM_CHAN-1:0] req,
	// Result
	output wire                     any,
	output wire [`VIP_CHAN_W-1:0]   win
);

	function [`VIP_CHAN_W-1:0] lowest_set;
		input [`VIP_NUM_CHAN-1:0] v;
		integer i;
		begin
			lowest_set = `VIP_RST_CHAN;
			// Descending scan so the smallest index is written last
			for (i = `VIP_NUM_CHAN - 1; i >= 0; i = i - 1) begin
				if (v[i]) begin
					lowest_set = i[`VIP_CHAN_W-1:0];
				end
			end
		end
	endfunction

	assign any = |req;
	assign win = lowest_set(req);

endmodule // vip_prio_enc

/* design/vip_prioritizer.v */
// Vectored interrupt prioritizer: maps peripheral requests to 64 channels,
// masks them, splits them into fast and normal lines and picks each winner.
// Assumes all sources are level requests from logic on clk_sys; no sync needed.
`include "vip_defs.vh"

module vip_prioritizer (
	// Clock and reset
	input  wire                     clk_sys,
	input  wire                     sys_rst,
	// Error signaling unit
	input  wire                     err_high_req,
	input  wire                     err_low_req,
	// OS tick timer
	input  wire [3:0]               tick_cmp_req,
	input  wire                     tick_ovf0_req,
	input  wire                     tick_ovf1_req,
	input  wire                     tick_tbase_req,
	// High-end timer and its transfer unit
	input  wire                     het_l1_req,
	input  wire                     het_l2_req,
	input  wire                     htu_l1_req,
	input  wire                     htu_l2_req,
	// Serial ports
	input  wire                     spi1_l0_req,
	input  wire                     spi1_l1_req,
	input  wire                     lip1_l0_req,
	input  wire                     lip1_l1_req,
	// Converter one
	input  wire                     adc1_evt_req,
	input  wire                     adc1_sw1_req,
	input  wire                     adc1_sw2_req,
	input  wire                     adc1_mag_req,
	// CAN, automotive bus, system
	input  wire                     can1_l0_req,
	input  wire                     can1_l1_req,
	input  wire                     dbus_l0_req,
	input  wire                     sw_int_req,
	// Other sources, one bit per channel, shared with the named ones
	input  wire [`VIP_NUM_CHAN-1:0] other_req,
	// Channel configuration
	input  wire [`VIP_NUM_CHAN-1:0] chan_enable,
	input  wire [`VIP_NUM_CHAN-1:0] chan_is_fast,
	// Fast line to the core
	output reg                      fast_interrupt_line,
	output reg  [`VIP_CHAN_W-1:0]   fast_channel,
	// Normal line to the core
	output reg                      normal_interrupt_line,
	output reg  [`VIP_CHAN_W-1:0]   normal_channel,
	// Status
	output reg  [`VIP_NUM_CHAN-1:0] pending
);

	reg  [`VIP_NUM_CHAN-1:0] chan_raw;
	wire [`VIP_NUM_CHAN-1:0] chan_live;
	wire [`VIP_NUM_CHAN-1:0] fast_req;
	wire [`VIP_NUM_CHAN-1:0] normal_req;
	wire                     next_fast_any;
	wire                     next_normal_any;
	wire [`VIP_CHAN_W-1:0]   next_fast_win;
	wire [`VIP_CHAN_W-1:0]   next_normal_win;
	integer                  k;

	// Default source placement; OR keeps any shared source able to fire the channel
	always @* begin
		chan_raw = other_req;
		chan_raw[`VIP_CH_ERR_HIGH]   = other_req[`VIP_CH_ERR_HIGH] | err_high_req;
		for (k = 0; k < 4; k = k + 1) begin
			chan_raw[`VIP_CH_TICK_CMP0 + k] = other_req[`VIP_CH_TICK_CMP0 + k]
				| tick_cmp_req[k];
		end
		chan_raw[`VIP_CH_TICK_OVF0]  = other_req[`VIP_CH_TICK_OVF0] | tick_ovf0_req;
		chan_raw[`VIP_CH_TICK_OVF1]  = other_req[`VIP_CH_TICK_OVF1] | tick_ovf1_req;
		chan_raw[`VIP_CH_TICK_TBASE] = other_req[`VIP_CH_TICK_TBASE] | tick_tbase_req;
		chan_raw[`VIP_CH_HET_L1]     = other_req[`VIP_CH_HET_L1] | het_l1_req;
		chan_raw[`VIP_CH_HET_L2]     = other_req[`VIP_CH_HET_L2] | het_l2_req;
		chan_raw[`VIP_CH_HTU_L1]     = other_req[`VIP_CH_HTU_L1] | htu_l1_req;
		chan_raw[`VIP_CH_HTU_L2]     = other_req[`VIP_CH_HTU_L2] | htu_l2_req;
		chan_raw[`VIP_CH_SPI1_L0]    = other_req[`VIP_CH_SPI1_L0] | spi1_l0_req;
		chan_raw[`VIP_CH_SPI1_L1]    = other_req[`VIP_CH_SPI1_L1] | spi1_l1_req;
		chan_raw[`VIP_CH_LIP1_L0]    = other_req[`VIP_CH_LIP1_L0] | lip1_l0_req;
		chan_raw[`VIP_CH_LIP1_L1]    = other_req[`VIP_CH_LIP1_L1] | lip1_l1_req;
		chan_raw[`VIP_CH_ADC1_EVT]   = other_req[`VIP_CH_ADC1_EVT] | adc1_evt_req;
		chan_raw[`VIP_CH_ADC1_SW1]   = other_req[`VIP_CH_ADC1_SW1] | adc1_sw1_req;
		chan_raw[`VIP_CH_ADC1_SW2]   = other_req[`VIP_CH_ADC1_SW2] | adc1_sw2_req;
		chan_raw[`VIP_CH_ADC1_MAG]   = other_req[`VIP_CH_ADC1_MAG] | adc1_mag_req;
		chan_raw[`VIP_CH_CAN1_L0]    = other_req[`VIP_CH_CAN1_L0] | can1_l0_req;
		chan_raw[`VIP_CH_CAN1_L1]    = other_req[`VIP_CH_CAN1_L1] | can1_l1_req;
		chan_raw[`VIP_CH_DBUS_L0]    = other_req[`VIP_CH_DBUS_L0] | dbus_l0_req;
		chan_raw[`VIP_CH_ERR_LOW]    = other_req[`VIP_CH_ERR_LOW] | err_low_req;
		chan_raw[`VIP_CH_SW_INT]     = other_req[`VIP_CH_SW_INT] | sw_int_req;
	end

	// Masking; no latching, so a request ends as soon as its source drops
	assign chan_live  = chan_raw & chan_enable;
	assign fast_req   = chan_live & chan_is_fast;
	assign normal_req = chan_live & ~chan_is_fast;

	vip_prio_enc u_fast_enc (
		.req (fast_req),
		.any (next_fast_any),
		.win (next_fast_win)
	);

	vip_prio_enc u_normal_enc (
		.req (normal_req),
		.any (next_normal_any),
		.win (next_normal_win)
	);

	// One register stage: costs a cycle of latency, keeps outputs glitch free
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			fast_interrupt_line   <= `VIP_RST_LINE;
			fast_channel          <= `VIP_RST_CHAN;
			normal_interrupt_line <= `VIP_RST_LINE;
			normal_channel        <= `VIP_RST_CHAN;
			pending               <= `VIP_RST_PEND;
		end else begin
			// Once raised the core cannot mask fast, so only the channel mask stops it
			fast_interrupt_line   <= next_fast_any;
			fast_channel          <= next_fast_win;
			normal_interrupt_line <= next_normal_any;
			normal_channel        <= next_normal_win;
			pending               <= chan_live;
		end
	end

endmodule // vip_prioritizer

/* sim/vip_chk.sv */
// Port assertions for the prioritizer.
// Assumes it is bound to vip_prioritizer, one clock, synchronous reset.
module vip_chk (
	// Clock, reset
	input wire        clk_sys,
	input wire        sys_rst,
	// Requests, configuration
	input wire        err_high_req,
	input wire [63:0] other_req,
	input wire [63:0] chan_enable,
	input wire [63:0] chan_is_fast,
	// Results
	input wire [63:0] pending,
	input wire        fast_interrupt_line,
	input wire        normal_interrupt_line,
	input wire [5:0]  fast_channel,
	input wire [5:0]  normal_channel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence src0_gone;
		!err_high_req && !other_req[0];
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> pending == 0 &&
		!fast_interrupt_line && !normal_interrupt_line) else $error("not cleared by reset");
	mask_block_a: assert property (1 |=> (pending & ~$past(chan_enable)) == 0)
		else $error("masked channel pending");
	share_chan_a: assert property (1 |=> ($past(other_req) & $past(chan_enable) & ~pending) == 0)
		else $error("shared source lost");
	chan_zero_a: assert property (err_high_req && chan_enable[0] |=> pending[0])
		else $error("channel 0 not raised");
	level_drop_a: assert property (src0_gone |=> !pending[0])
		else $error("channel 0 stuck");
	fast_line_a: assert property (1 |=> fast_interrupt_line == |(pending & $past(chan_is_fast)))
		else $error("fast line wrong");
	norm_line_a: assert property (1 |=> normal_interrupt_line == |(pending & ~$past(chan_is_fast)))
		else $error("normal line wrong");
	fast_win_a: assert property (fast_interrupt_line |-> pending[fast_channel] &&
		(pending & $past(chan_is_fast) & ((64'h1 << fast_channel) - 64'h1)) == 0)
		else $error("fast winner not lowest");
	norm_idle_a: assert property (!normal_interrupt_line |-> normal_channel == 6'h00)
		else $error("idle normal index not zero");
endmodule // vip_chk

bind vip_prioritizer vip_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.err_high_req(err_high_req), .other_req(other_req), .chan_enable(chan_enable),
	.chan_is_fast(chan_is_fast), .pending(pending), .fast_interrupt_line(fast_interrupt_line),
	.normal_interrupt_line(normal_interrupt_line), .fast_channel(fast_channel),
	.normal_channel(normal_channel));

/* sim/vip_core_model.sv */
// Core side model: takes the fast and normal lines.
// Assumes the lines come straight from the prioritizer.
module vip_core_model (
	// From prioritizer
	input wire fast_interrupt_line,
	input wire normal_interrupt_line,
	// Core disable bit
	input wire irq_block,
	// Taken
	output wire fast_taken,
	output wire normal_taken
);
	timeunit 1ns;
	timeprecision 100ps;
	// Disable bit cannot hold off the fast line
	assign fast_taken = fast_interrupt_line;
	assign normal_taken = normal_interrupt_line & ~irq_block;
endmodule // vip_core_model

/* sim/vip_prioritizer_tb.sv */
// Testbench: reference model compared with the design every cycle.
// Assumes vip_prioritizer, vip_core_model and vip_chk are compiled.
module vip_prioritizer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	int ch[25] = '{0,20,2,3,4,5,6,7,8,10,24,11,25,12,26,13,27,14,15,28,31,16,29,18,21};
	int err_total = 0;
	int cmp_count = 0;
	integer seed = 32'hd6db;
	logic clk_sys = 0, sys_rst = 1, irq_block = 0, xf = 0, xn = 0;
	logic [24:0] src = 0;
	logic [63:0] oth = 0, en = 0, fst = 0, xp = 0;
	logic [5:0] xfc = 0, xnc = 0;
	wire [63:0] pending;
	wire fast_interrupt_line, normal_interrupt_line, fast_taken, normal_taken;
	wire [5:0] fast_channel, normal_channel;
	initial forever #25 clk_sys = ~clk_sys;
	vip_prioritizer uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .err_high_req(src[0]),
		.err_low_req(src[1]), .tick_cmp_req(src[5:2]), .tick_ovf0_req(src[6]),
		.tick_ovf1_req(src[7]), .tick_tbase_req(src[8]), .het_l1_req(src[9]),
		.het_l2_req(src[10]), .htu_l1_req(src[11]), .htu_l2_req(src[12]),
		.spi1_l0_req(src[13]), .spi1_l1_req(src[14]), .lip1_l0_req(src[15]),
		.lip1_l1_req(src[16]), .adc1_evt_req(src[17]), .adc1_sw1_req(src[18]),
		.adc1_sw2_req(src[19]), .adc1_mag_req(src[20]), .can1_l0_req(src[21]),
		.can1_l1_req(src[22]), .dbus_l0_req(src[23]), .sw_int_req(src[24]), .other_req(oth),
		.chan_enable(en), .chan_is_fast(fst), .fast_interrupt_line(fast_interrupt_line),
		.fast_channel(fast_channel), .normal_interrupt_line(normal_interrupt_line),
		.normal_channel(normal_channel), .pending(pending));
	vip_core_model core (.fast_interrupt_line(fast_interrupt_line),
		.normal_interrupt_line(normal_interrupt_line), .irq_block(irq_block),
		.fast_taken(fast_taken), .normal_taken(normal_taken));
	task miss(input string what, input logic [63:0] got, input logic [63:0] want);
		err_total++;
		$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
	endtask
	task chk_pend(input logic [63:0] got, input logic [63:0] want);
		cmp_count++;
		if (got !== want) miss("pending", got, want);
	endtask
	task chk_line(input logic [6:0] got, input logic [6:0] want);
		cmp_count++;
		if (got !== want) miss("line and channel", 64'(got), 64'(want));
	endtask
	task chk_taken(input logic [1:0] got, input logic [1:0] want);
		cmp_count++;
		if (got !== want) miss("core taken", 64'(got), 64'(want));
	endtask
	task final_report;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Check the last result, then drive the next inputs 5 ns after the edge
	task cyc(input logic r, input logic [24:0] s, input logic [63:0] o, e, f);
		@(posedge clk_sys);
		#1;
		chk_pend(pending, xp);
		chk_line({fast_interrupt_line, fast_channel}, {xf, xfc});
		chk_line({normal_interrupt_line, normal_channel}, {xn, xnc});
		chk_taken({fast_taken, normal_taken}, {xf, xn & ~irq_block});
		#4;
		{sys_rst, src, oth, en, fst} = {r, s, o, e, f};
		irq_block = $random(seed);
		xp = o;
		for (int i = 0; i < 25; i++) if (s[i]) xp[ch[i]] = 1'b1;
		xp = r ? 64'h0 : xp & e;
		{xf, xn, xfc, xnc} = 0;
		for (int i = 63; i >= 0; i--) begin
			if (xp[i] & f[i]) {xf, xfc} = {1'b1, 6'(i)};
			if (xp[i] & ~f[i]) {xn, xnc} = {1'b1, 6'(i)};
		end
	endtask
	task rnd(input int n);
		repeat (n) cyc(0, 25'($random(seed)), {$random(seed), $random(seed)}
			& {$random(seed), $random(seed)}, {$random(seed), $random(seed)}
			| {$random(seed), $random(seed)}, {$random(seed), $random(seed)});
	endtask
	initial begin
		repeat (16) cyc(1, 0, 0, 0, 0);
		for (int k = 0; k < 25; k++) cyc(0, 25'h1 << k, 0, '1, {64{k[0]}});
		for (int k = 0; k < 25; k++) cyc(0, 25'h1 << k, 64'h1 << ch[k], '1, 0);
		cyc(0, 0, 64'h0000_0000_4002_0002, '1, 0);
		rnd(400);
		cyc(1, '1, '1, '1, '1);
		rnd(100);
		cyc(0, 0, 0, '1, 0);
		cyc(0, 0, 0, '1, 0);
		final_report;
	end
	initial begin
		#2_000_000;
		err_total++;
		final_report;
	end
endmodule // vip_prioritizer_tb
